// ==== dv/idu_checker_assertions.sv ====
// Purpose: port checks for the integer divide unit
// Assumes: the bench offers write address and data together
// Notes: the carry bit is tracked from software writes only
`timescale 1ns/1ps
`include "idu_consts.vh"
module idu_checker (
  // clock and reset
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  // write channels
  input wire [5:0] AXI_AWADDR_IN,
  input wire AXI_AWVALID_IN,
  input wire AXI_AWREADY_OUT,
  input wire [31:0] AXI_WDATA_IN,
  input wire [3:0] AXI_WSTRB_IN,
  input wire AXI_WVALID_IN,
  input wire AXI_WREADY_OUT,
  input wire [1:0] AXI_BRESP_OUT,
  input wire AXI_BVALID_OUT,
  input wire AXI_BREADY_IN,
  // read channels
  input wire [5:0] AXI_ARADDR_IN,
  input wire AXI_ARVALID_IN,
  input wire AXI_ARREADY_OUT,
  input wire [31:0] AXI_RDATA_OUT,
  input wire [1:0] AXI_RRESP_OUT,
  input wire AXI_RVALID_OUT,
  input wire AXI_RREADY_IN,
  // interrupt
  input wire IRQ_OUT
);
  reg ca;
  reg [5:0] ra;
  wire aw_w = AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
  wire ar_hs = AXI_ARVALID_IN && AXI_ARREADY_OUT;
  default clocking @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // carry as software last left it; no divide may move it
  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ca <= 1'b0;
      ra <= 6'h00;
    end
    else
    begin
      if (aw_w && AXI_AWADDR_IN == `IDU_OFS_XER && AXI_WSTRB_IN[3])
        ca <= AXI_WDATA_IN[`IDU_XER_CA];
      if (ar_hs)
        ra <= AXI_ARADDR_IN;
    end
  end
  carry_keep_a: assert property (AXI_RVALID_OUT && ra == `IDU_OFS_XER |->
    AXI_RDATA_OUT[`IDU_XER_CA] == ca) else $error("carry flag changed");
  wr_answer_a: assert property (aw_w |-> ##2 AXI_BVALID_OUT)
    else $error("write response late");
  rd_answer_a: assert property (ar_hs |=> AXI_RVALID_OUT)
    else $error("read data late");
  bv_single_a: assert property (AXI_BVALID_OUT && AXI_BREADY_IN |=> !AXI_BVALID_OUT)
    else $error("write response repeated");
  rv_single_a: assert property (AXI_RVALID_OUT && AXI_RREADY_IN |=> !AXI_RVALID_OUT)
    else $error("read data repeated");
  wr_block_a: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
    else $error("write taken during response");
  rd_block_a: assert property (AXI_RVALID_OUT |-> !AXI_ARREADY_OUT)
    else $error("read taken during data");
  bad_read_a: assert property (ar_hs && (AXI_ARADDR_IN > `IDU_OFS_IRQ_MASK ||
    AXI_ARADDR_IN[1:0] != 2'b00) |=> AXI_RRESP_OUT == `IDU_RESP_SLVERR &&
    AXI_RDATA_OUT == 32'h0) else $error("unmapped read not refused");
  cover property (AXI_BVALID_OUT && AXI_BREADY_IN);
  cover property (AXI_RVALID_OUT && AXI_RREADY_IN);
  cover property ($rose(IRQ_OUT));
endmodule
bind idu_top idu_checker i_chk (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
  .AXI_AWADDR_IN(AXI_AWADDR_IN), .AXI_AWVALID_IN(AXI_AWVALID_IN),
  .AXI_AWREADY_OUT(AXI_AWREADY_OUT), .AXI_WDATA_IN(AXI_WDATA_IN),
  .AXI_WSTRB_IN(AXI_WSTRB_IN), .AXI_WVALID_IN(AXI_WVALID_IN),
  .AXI_WREADY_OUT(AXI_WREADY_OUT), .AXI_BRESP_OUT(AXI_BRESP_OUT),
  .AXI_BVALID_OUT(AXI_BVALID_OUT), .AXI_BREADY_IN(AXI_BREADY_IN),
  .AXI_ARADDR_IN(AXI_ARADDR_IN), .AXI_ARVALID_IN(AXI_ARVALID_IN),
  .AXI_ARREADY_OUT(AXI_ARREADY_OUT), .AXI_RDATA_OUT(AXI_RDATA_OUT),
  .AXI_RRESP_OUT(AXI_RRESP_OUT), .AXI_RVALID_OUT(AXI_RVALID_OUT),
  .AXI_RREADY_IN(AXI_RREADY_IN), .IRQ_OUT(IRQ_OUT));

// ==== dv/idu_host_model.sv ====
// Purpose: decoder side model, issues register bus transfers
// Assumes: one transfer at a time, called from the bench
// Notes: a wait that runs out returns response 2'b11
`timescale 1ns/1ps
module idu_host_model (
  // clock
  input wire clk_in,
  // write side
  output reg [5:0] awaddr_out = 6'h00,
  output reg awvalid_out = 1'b0,
  input wire awready_in,
  output reg [31:0] wdata_out = 32'h0,
  output reg [3:0] wstrb_out = 4'h0,
  output reg wvalid_out = 1'b0,
  input wire wready_in,
  input wire [1:0] bresp_in,
  input wire bvalid_in,
  output reg bready_out = 1'b0,
  // read side
  output reg [5:0] araddr_out = 6'h00,
  output reg arvalid_out = 1'b0,
  input wire arready_in,
  input wire [31:0] rdata_in,
  input wire [1:0] rresp_in,
  input wire rvalid_in,
  output reg rready_out = 1'b0
);
  // address and data offered together, each dropped when taken
  task wr(input [5:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    integer n;
    reg dn;
    begin
      dn = 1'b0;
      r = 2'b11;
      @(posedge clk_in);
      awaddr_out <= a;
      wdata_out <= d;
      wstrb_out <= s;
      awvalid_out <= 1'b1;
      wvalid_out <= 1'b1;
      bready_out <= 1'b1;
      for (n = 0; n < 100 && !dn; n = n + 1)
      begin
        @(posedge clk_in);
        if (awvalid_out && awready_in)
          awvalid_out <= 1'b0;
        if (wvalid_out && wready_in)
          wvalid_out <= 1'b0;
        if (bvalid_in)
        begin
          r = bresp_in;
          bready_out <= 1'b0;
          dn = 1'b1;
        end
      end
    end
  endtask
  // read data is taken at the edge where it is seen valid
  task rd(input [5:0] a, output [31:0] d, output [1:0] r);
    integer n;
    reg dn;
    begin
      dn = 1'b0;
      r = 2'b11;
      d = 32'hx;
      @(posedge clk_in);
      araddr_out <= a;
      arvalid_out <= 1'b1;
      rready_out <= 1'b1;
      for (n = 0; n < 100 && !dn; n = n + 1)
      begin
        @(posedge clk_in);
        if (arvalid_out && arready_in)
          arvalid_out <= 1'b0;
        if (rvalid_in)
        begin
          d = rdata_in;
          r = rresp_in;
          rready_out <= 1'b0;
          dn = 1'b1;
        end
      end
    end
  endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the integer divide unit
// Assumes: busy lasts 65 cycles after an instruction write
// Notes: undefined overflow results are not compared
`timescale 1ns/1ps
`include "idu_consts.vh"
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  integer miscompares = 0;
  integer checks_done = 0;
  integer i;
  reg [1:0] r;
  reg [31:0] d;
  wire [5:0] awa, ara;
  wire [31:0] wd, rdat;
  wire [3:0] ws;
  wire [1:0] br, rr;
  wire awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry, irq;
  always #2 clk = ~clk;
  idu_top i_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .AXI_AWADDR_IN(awa),
    .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(ws),
    .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wrd), .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv),
    .AXI_BREADY_IN(bry), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv),
    .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rr),
    .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rry), .IRQ_OUT(irq));
  idu_host_model i_host (.clk_in(clk), .awaddr_out(awa), .awvalid_out(awv),
    .awready_in(awr), .wdata_out(wd), .wstrb_out(ws), .wvalid_out(wv), .wready_in(wrd),
    .bresp_in(br), .bvalid_in(bv), .bready_out(bry), .araddr_out(ara),
    .arvalid_out(arv), .arready_in(arr), .rdata_in(rdat), .rresp_in(rr),
    .rvalid_in(rv), .rready_out(rry));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
        miscompares = miscompares + 1;
      end
    end
  endtask
  task ww(input [5:0] a, input [31:0] v);
    begin
      i_host.wr(a, v, 4'hf, r);
      chk("bresp", {30'h0, `IDU_RESP_OKAY}, {30'h0, r});
    end
  endtask
  task ww64(input [5:0] a, input [63:0] v);
    begin
      ww(a, v[31:0]);
      ww(a + 6'h04, v[63:32]);
    end
  endtask
  task rc(input [5:0] a, input [31:0] e);
    begin
      i_host.rd(a, d, r);
      chk($sformatf("reg %h", a), e, d);
    end
  endtask
  // issue, see busy, let the 65 busy cycles run out
  task run(input [31:0] ins);
    begin
      ww(`IDU_OFS_INSN, ins);
      rc(`IDU_OFS_STAT, 32'h1);
      repeat (70) @(posedge clk);
      rc(`IDU_OFS_STAT, 32'h0);
    end
  endtask
  function [31:0] op(input [8:0] e, input oe, input rb);
    op = {`IDU_PRIMARY_OP, 15'h0, oe, e, rb};
  endfunction
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // watchdog against a stuck bus
  initial
  begin
    repeat (50000) @(posedge clk);
    miscompares = miscompares + 1;
    complete_run;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 13; i = i + 1)
      rc({i[3:0], 2'b00}, 32'h0);
    $display("test reset done");
    i_host.wr(6'h34, 32'h1, 4'hf, r);
    chk("bresp", {30'h0, `IDU_RESP_SLVERR}, {30'h0, r});
    i_host.rd(6'h34, d, r);
    chk("rresp", {30'h0, `IDU_RESP_SLVERR}, {30'h0, r});
    $display("test unmapped done");
    ww(`IDU_OFS_XER, 32'h20000000);
    ww(`IDU_OFS_OPA_LO, 32'hffffffff);
    ww(`IDU_OFS_QEXT, 32'hfffffff9);
    ww(`IDU_OFS_OPB_LO, 32'h2);
    run(op(`IDU_EXT_DIV32, 1'b0, 1'b1));
    rc(`IDU_OFS_RES_LO, 32'hfffffffd);
    rc(`IDU_OFS_QEXT, 32'hffffffff);
    rc(`IDU_OFS_XER, 32'h20000000);
    rc(`IDU_OFS_CR0, 32'h8);
    $display("test word_signed done");
    ww(`IDU_OFS_OPA_LO, 32'h1);
    ww(`IDU_OFS_QEXT, 32'h0);
    ww(`IDU_OFS_OPB_LO, 32'h4);
    run(op(`IDU_EXT_DIV32, 1'b1, 1'b0));
    rc(`IDU_OFS_RES_LO, 32'h40000000);
    rc(`IDU_OFS_QEXT, 32'h0);
    rc(`IDU_OFS_XER, 32'h20000000);
    rc(`IDU_OFS_CR0, 32'h8);
    $display("test word_wide done");
    ww(`IDU_OFS_OPA_LO, 32'hffffffff);
    ww(`IDU_OFS_QEXT, 32'h80000000);
    ww(`IDU_OFS_OPB_LO, 32'hffffffff);
    run(op(`IDU_EXT_DIV32, 1'b1, 1'b1));
    rc(`IDU_OFS_RES_LO, 32'h80000000);
    rc(`IDU_OFS_QEXT, 32'h0);
    rc(`IDU_OFS_XER, 32'he0000000);
    rc(`IDU_OFS_CR0, 32'h9);
    $display("test word_min done");
    ww(`IDU_OFS_XER, 32'h0);
    ww(`IDU_OFS_OPB_LO, 32'h0);
    run(op(`IDU_EXT_DIV32, 1'b1, 1'b0));
    rc(`IDU_OFS_XER, 32'hc0000000);
    rc(`IDU_OFS_IRQ_STAT, 32'h3);
    chk("irq", 32'h0, {31'h0, irq});
    ww(`IDU_OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    ww(`IDU_OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rc(`IDU_OFS_IRQ_STAT, 32'h1);
    $display("test word_zero done");
    ww(`IDU_OFS_XER, 32'h0);
    ww(`IDU_OFS_QEXT, 32'h12345678);
    ww64(`IDU_OFS_OPA_LO, 64'hffffffff_fffffff9);
    ww64(`IDU_OFS_OPB_LO, 64'h2);
    run(op(`IDU_EXT_DIVD, 1'b0, 1'b1));
    rc(`IDU_OFS_RES_LO, 32'hfffffffd);
    rc(`IDU_OFS_RES_HI, 32'hffffffff);
    rc(`IDU_OFS_QEXT, 32'h12345678);
    rc(`IDU_OFS_CR0, 32'h8);
    $display("test dword done");
    for (i = 0; i < 4; i = i + 1)
    begin
      ww(`IDU_OFS_CR0, 32'h0);
      ww(`IDU_OFS_XER, 32'h0);
      run(op(`IDU_EXT_DIVDU, i[1], i[0]));
      rc(`IDU_OFS_RES_HI, 32'h7fffffff);
      rc(`IDU_OFS_RES_LO, 32'hfffffffc);
      rc(`IDU_OFS_CR0, i[0] ? 32'h4 : 32'h0);
      rc(`IDU_OFS_XER, 32'h0);
    end
    $display("test dword_uns done");
    ww64(`IDU_OFS_OPA_LO, 64'h80000000_00000000);
    for (i = 0; i < 2; i = i + 1)
    begin
      ww(`IDU_OFS_XER, 32'h0);
      ww64(`IDU_OFS_OPB_LO, i ? 64'h0 : 64'hffffffff_ffffffff);
      run(op(`IDU_EXT_DIVD, 1'b1, 1'b0));
      rc(`IDU_OFS_XER, 32'hc0000000);
    end
    $display("test dword_ovf done");
    for (i = 0; i < 2; i = i + 1)
    begin
      ww(`IDU_OFS_IRQ_STAT, 32'h7);
      ww(`IDU_OFS_INSN, i ? op(9'h000, 1'b0, 1'b0) : op(`IDU_EXT_DIVD, 1'b0, 1'b0) ^ 32'h04000000);
      rc(`IDU_OFS_IRQ_STAT, 32'h4);
      rc(`IDU_OFS_STAT, 32'h0);
    end
    $display("test illegal done");
    complete_run;
  end
endmodule

// ==== hdl/idu_consts.vh ====
// Purpose: constants for the integer divide unit
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes: instruction fields use big-endian bit numbering (bit 0 = msb)
`ifndef IDU_CONSTS_VH
`define IDU_CONSTS_VH

// register byte offsets
`define IDU_OFS_OPA_LO 6'h00
`define IDU_OFS_OPA_HI 6'h04
`define IDU_OFS_OPB_LO 6'h08
`define IDU_OFS_OPB_HI 6'h0c
`define IDU_OFS_QEXT 6'h10
`define IDU_OFS_INSN 6'h14
`define IDU_OFS_RES_LO 6'h18
`define IDU_OFS_RES_HI 6'h1c
`define IDU_OFS_XER 6'h20
`define IDU_OFS_CR0 6'h24
`define IDU_OFS_STAT 6'h28
`define IDU_OFS_IRQ_STAT 6'h2c
`define IDU_OFS_IRQ_MASK 6'h30

// instruction decode
`define IDU_PRIMARY_OP 6'h1f
`define IDU_EXT_DIV32 9'h14b
`define IDU_EXT_DIVD 9'h1e9
`define IDU_EXT_DIVDU 9'h1c9
`define IDU_IMPL_64BIT 1'b1

// exception register bit positions
`define IDU_XER_SO 31
`define IDU_XER_OV 30
`define IDU_XER_CA 29

// condition field bit positions
`define IDU_CR_LT 3
`define IDU_CR_GT 2
`define IDU_CR_EQ 1
`define IDU_CR_SO 0

// interrupt status bit positions
`define IDU_EV_DONE 0
`define IDU_EV_OVF 1
`define IDU_EV_ILL 2

// divider timing and axi responses
`define IDU_DIV_STEPS 7'd64
`define IDU_RESP_OKAY 2'b00
`define IDU_RESP_SLVERR 2'b10

`endif

// ==== hdl/idu_top.v ====
// Purpose: integer divide unit with AXI4-Lite register access
// Assumes: single clock, inputs synchronous to REF_CLK_IN
// Notes: 64-step restoring divider on magnitudes, signs fixed at the end
// Overview of operation
// RULE1: the word divide uses first operand (high) and quotient extension (low) as dividend.
// RULE2: a good word divide writes quotient to the result and remainder to the extension.
// RULE3: the word remainder takes the dividend sign, and zero results are positive.
// RULE4: minus two to the 31 over minus one gives extension zero and result minus two to the 31.
// RULE5: other word overflows leave result, extension and recorded field undefined.
// RULE6: with overflow-enable set, summary and overflow flags update, else they stay.
// RULE7: with the record bit set, the condition field takes sign, zero and summary bits.
// RULE8: the word divide never touches the carry flag.
// RULE9: the doubleword divide writes only a 64-bit quotient, with no remainder.
// RULE10: the signed doubleword divide truncates toward zero on signed operands.
// RULE11: signed doubleword most-negative over minus one or by zero is undefined and overflows.
// RULE12: doubleword divides are illegal on a 32-bit implementation.
// RULE13: signed doubleword decodes from opcode 31, extended 489, enable bit 21, record bit 31.
// RULE14: unsigned doubleword decodes from extended 457 in all four enable and record forms.
// RULE15: unsigned doubleword is unsigned but records by a signed compare with zero.
// RULE16: a word divide by zero is an overflow with undefined results.
`timescale 1ns/1ps
`include "idu_consts.vh"

module idu_top (
  // clock and reset
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  // axi write address and data
  input wire [5:0] AXI_AWADDR_IN,
  input wire AXI_AWVALID_IN,
  output reg AXI_AWREADY_OUT,
  input wire [31:0] AXI_WDATA_IN,
  input wire [3:0] AXI_WSTRB_IN,
  input wire AXI_WVALID_IN,
  output reg AXI_WREADY_OUT,
  // axi write response
  output reg [1:0] AXI_BRESP_OUT,
  output reg AXI_BVALID_OUT,
  input wire AXI_BREADY_IN,
  // axi read
  input wire [5:0] AXI_ARADDR_IN,
  input wire AXI_ARVALID_IN,
  output reg AXI_ARREADY_OUT,
  output reg [31:0] AXI_RDATA_OUT,
  output reg [1:0] AXI_RRESP_OUT,
  output reg AXI_RVALID_OUT,
  input wire AXI_RREADY_IN,
  // interrupt
  output reg IRQ_OUT
);

  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_DONE = 3'b100;
  localparam M_DIV32 = 3'b001;
  localparam M_DIVD = 3'b010;
  localparam M_DIVDU = 3'b100;

  reg [2:0] state;
  reg [2:0] mode;
  reg [6:0] step;
  reg oe;
  reg rc;
  reg neg_n;
  reg neg_q;
  reg dz;
  reg spec;
  reg [63:0] quo;
  reg [63:0] rem;
  reg [63:0] dvs;
  reg [63:0] opa;
  reg [63:0] opb;
  reg [31:0] quotient_extension_register;
  reg [31:0] insn;
  reg [63:0] res;
  reg summary_flag;
  reg overflow_flag;
  reg carry_flag;
  reg [3:0] condition_field_zero;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg [5:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  // apply byte strobes to a register word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // magnitude of a value that is negative when neg is set
  function [63:0] mag;
    input [63:0] v;
    input neg;
    begin
      mag = neg ? (~v + 64'h1) : v;
    end
  endfunction

  // offset decode shared by read and write paths
  function mapped;
    input [5:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `IDU_OFS_IRQ_MASK);
    end
  endfunction

  // strobed images of the narrow registers; only their low bits are kept
  wire [31:0] cr_word = merge({28'h0, condition_field_zero}, w_data, w_strb);
  wire [31:0] mask_word = merge({29'h0, irq_mask}, w_data, w_strb);

  // dividend and divisor selection for a new operation
  wire [63:0] dvd_32 = {opa[31:0], quotient_extension_register}; // RULE1
  wire [63:0] dvs_32 = {{32{opb[31]}}, opb[31:0]};

  // one restoring step
  wire [64:0] trial = {rem, quo[63]} - {1'b0, dvs};

  // sign-corrected results; a zero magnitude stays positive after negation
  wire [63:0] qs = mag(quo, neg_q); // RULE10
  wire [63:0] rs = mag(rem, neg_n); // RULE3
  wire q_fits32 = (qs[63:31] == {33{qs[31]}});
  wire ovf = (mode == M_DIV32) ? (dz | ~q_fits32) : // RULE16 RULE5
             (mode == M_DIVD) ? (dz | spec) : dz; // RULE11
  wire [63:0] next_res = (mode == M_DIV32) ?
                         (spec ? 64'hffffffff80000000 : {{32{qs[31]}}, qs[31:0]}) : qs;
  wire res_neg = (mode == M_DIV32) ? next_res[31] : next_res[63]; // RULE15
  wire res_zero = (mode == M_DIV32) ? (next_res[31:0] == 32'h0) : (next_res == 64'h0);
  wire next_so = oe ? (summary_flag | ovf) : summary_flag;

  // axi write fires once address and data are both held
  wire do_write = aw_held & w_held & ~AXI_BVALID_OUT;
  wire wr_ok = do_write & mapped(aw_addr);
  wire start_wr = wr_ok & (aw_addr == `IDU_OFS_INSN) & (state == ST_IDLE);

  // decode of the written instruction word
  wire [31:0] new_insn = merge(insn, w_data, w_strb);
  wire is_d32 = (new_insn[9:1] == `IDU_EXT_DIV32);
  wire is_dd = (new_insn[9:1] == `IDU_EXT_DIVD); // RULE13
  wire is_du = (new_insn[9:1] == `IDU_EXT_DIVDU); // RULE14
  wire is_64 = is_dd | is_du;
  wire legal = (new_insn[31:26] == `IDU_PRIMARY_OP) &
               (is_d32 | (is_64 & `IDU_IMPL_64BIT)); // RULE12

  // events: set wins over a write-one clear in the same cycle
  wire ev_done = (state == ST_DONE);
  wire ev_ovf = ev_done & ovf;
  wire ev_ill = start_wr & ~legal;
  wire [2:0] ev = {ev_ill, ev_ovf, ev_done};
  wire clr_hit = wr_ok & (aw_addr == `IDU_OFS_IRQ_STAT);
  wire [31:0] clr_word = merge(32'h0, w_data, w_strb);
  wire [2:0] clr = clr_hit ? clr_word[2:0] : 3'h0;
  wire [2:0] next_irq_stat = (irq_stat & ~clr[2:0]) | ev;

  // axi channel handshakes
  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      AXI_AWREADY_OUT <= 1'b1;
      AXI_WREADY_OUT <= 1'b1;
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT <= `IDU_RESP_OKAY;
      AXI_ARREADY_OUT <= 1'b1;
      AXI_RVALID_OUT <= 1'b0;
      AXI_RRESP_OUT <= `IDU_RESP_OKAY;
      AXI_RDATA_OUT <= 32'h0;
      aw_addr <= 6'h0;
      aw_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      w_held <= 1'b0;
    end
    else
    begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT)
      begin
        aw_addr <= AXI_AWADDR_IN;
        aw_held <= 1'b1;
        AXI_AWREADY_OUT <= 1'b0;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT)
      begin
        w_data <= AXI_WDATA_IN;
        w_strb <= AXI_WSTRB_IN;
        w_held <= 1'b1;
        AXI_WREADY_OUT <= 1'b0;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        AXI_BVALID_OUT <= 1'b1;
        AXI_BRESP_OUT <= mapped(aw_addr) ? `IDU_RESP_OKAY : `IDU_RESP_SLVERR;
      end
      // ready returns only after the response, so one write at a time
      if (AXI_BVALID_OUT && AXI_BREADY_IN)
      begin
        AXI_BVALID_OUT <= 1'b0;
        AXI_AWREADY_OUT <= 1'b1;
        AXI_WREADY_OUT <= 1'b1;
      end
      if (AXI_ARVALID_IN && AXI_ARREADY_OUT)
      begin
        AXI_ARREADY_OUT <= 1'b0;
        AXI_RVALID_OUT <= 1'b1;
        AXI_RRESP_OUT <= mapped(AXI_ARADDR_IN) ? `IDU_RESP_OKAY : `IDU_RESP_SLVERR;
        case (AXI_ARADDR_IN)
          `IDU_OFS_OPA_LO: AXI_RDATA_OUT <= opa[31:0];
          `IDU_OFS_OPA_HI: AXI_RDATA_OUT <= opa[63:32];
          `IDU_OFS_OPB_LO: AXI_RDATA_OUT <= opb[31:0];
          `IDU_OFS_OPB_HI: AXI_RDATA_OUT <= opb[63:32];
          `IDU_OFS_QEXT: AXI_RDATA_OUT <= quotient_extension_register;
          `IDU_OFS_INSN: AXI_RDATA_OUT <= insn;
          `IDU_OFS_RES_LO: AXI_RDATA_OUT <= res[31:0];
          `IDU_OFS_RES_HI: AXI_RDATA_OUT <= res[63:32];
          `IDU_OFS_XER: AXI_RDATA_OUT <= {summary_flag, overflow_flag, carry_flag, 29'h0};
          `IDU_OFS_CR0: AXI_RDATA_OUT <= {28'h0, condition_field_zero};
          `IDU_OFS_STAT: AXI_RDATA_OUT <= {31'h0, ~state[0]};
          `IDU_OFS_IRQ_STAT: AXI_RDATA_OUT <= {29'h0, irq_stat};
          `IDU_OFS_IRQ_MASK: AXI_RDATA_OUT <= {29'h0, irq_mask};
          default: AXI_RDATA_OUT <= 32'h0;
        endcase
      end
      if (AXI_RVALID_OUT && AXI_RREADY_IN)
      begin
        AXI_RVALID_OUT <= 1'b0;
        AXI_ARREADY_OUT <= 1'b1;
      end
    end
  end

  // register file, divider sequencer and write-back
  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state <= ST_IDLE;
      mode <= M_DIV32;
      step <= 7'h0;
      oe <= 1'b0;
      rc <= 1'b0;
      neg_n <= 1'b0;
      neg_q <= 1'b0;
      dz <= 1'b0;
      spec <= 1'b0;
      quo <= 64'h0;
      rem <= 64'h0;
      dvs <= 64'h0;
      opa <= 64'h0;
      opb <= 64'h0;
      quotient_extension_register <= 32'h0;
      insn <= 32'h0;
      res <= 64'h0;
      summary_flag <= 1'b0;
      overflow_flag <= 1'b0;
      carry_flag <= 1'b0;
      condition_field_zero <= 4'h0;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      IRQ_OUT <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      IRQ_OUT <= |(irq_stat & irq_mask);
      // software writes; operands are latched at start so edits while busy are safe
      if (wr_ok)
      begin
        case (aw_addr)
          `IDU_OFS_OPA_LO: opa[31:0] <= merge(opa[31:0], w_data, w_strb);
          `IDU_OFS_OPA_HI: opa[63:32] <= merge(opa[63:32], w_data, w_strb);
          `IDU_OFS_OPB_LO: opb[31:0] <= merge(opb[31:0], w_data, w_strb);
          `IDU_OFS_OPB_HI: opb[63:32] <= merge(opb[63:32], w_data, w_strb);
          `IDU_OFS_QEXT:
            if (state == ST_IDLE)
              quotient_extension_register <= merge(quotient_extension_register, w_data, w_strb);
          `IDU_OFS_INSN:
            if (state == ST_IDLE)
              insn <= new_insn;
          `IDU_OFS_XER:
            if (state == ST_IDLE)
            begin
              summary_flag <= w_strb[3] ? w_data[`IDU_XER_SO] : summary_flag;
              overflow_flag <= w_strb[3] ? w_data[`IDU_XER_OV] : overflow_flag;
              carry_flag <= w_strb[3] ? w_data[`IDU_XER_CA] : carry_flag;
            end
          `IDU_OFS_CR0:
            if (state == ST_IDLE)
              condition_field_zero <= cr_word[3:0];
          `IDU_OFS_IRQ_MASK: irq_mask <= mask_word[2:0];
          default: ;
        endcase
      end
      case (state)
        ST_IDLE:
          // a legal instruction write launches the divide
          if (start_wr && legal)
          begin
            state <= ST_RUN;
            step <= 7'h0;
            oe <= new_insn[10];
            rc <= new_insn[0];
            rem <= 64'h0;
            if (is_d32)
            begin
              mode <= M_DIV32;
              neg_n <= dvd_32[63];
              neg_q <= dvd_32[63] ^ dvs_32[63];
              quo <= mag(dvd_32, dvd_32[63]);
              dvs <= mag(dvs_32, dvs_32[63]);
              dz <= (dvs_32 == 64'h0);
              spec <= (dvd_32 == 64'hffffffff80000000) && (dvs_32 == 64'hffffffffffffffff);
            end
            else if (is_dd)
            begin
              mode <= M_DIVD;
              neg_n <= opa[63];
              neg_q <= opa[63] ^ opb[63];
              quo <= mag(opa, opa[63]);
              dvs <= mag(opb, opb[63]);
              dz <= (opb == 64'h0);
              spec <= (opa == 64'h8000000000000000) && (opb == 64'hffffffffffffffff);
            end
            else
            begin
              mode <= M_DIVDU;
              neg_n <= 1'b0;
              neg_q <= 1'b0;
              quo <= opa;
              dvs <= opb;
              dz <= (opb == 64'h0);
              spec <= 1'b0;
            end
          end
        ST_RUN:
        begin
          // one quotient bit per cycle; a zero divisor just yields all ones
          if (!trial[64])
          begin
            rem <= trial[63:0];
            quo <= {quo[62:0], 1'b1};
          end
          else
          begin
            rem <= {rem[62:0], quo[63]};
            quo <= {quo[62:0], 1'b0};
          end
          step <= step + 7'h1;
          if (step == `IDU_DIV_STEPS - 7'h1)
            state <= ST_DONE;
        end
        ST_DONE:
        begin
          state <= ST_IDLE;
          res <= next_res; // RULE2 RULE9
          if (mode == M_DIV32)
            quotient_extension_register <= spec ? 32'h0 : rs[31:0]; // RULE4 RULE2
          if (oe)
          begin
            overflow_flag <= ovf; // RULE6
            summary_flag <= next_so; // RULE6
          end
          // carry_flag is never written by a divide RULE8
          if (rc)
            condition_field_zero <= {res_neg, ~res_neg & ~res_zero, res_zero, next_so}; // RULE7
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
